// >>> verilog/dram_board_pkg.sv
// shared constants and types for the parity dram memory board
package dram_board_pkg;
   // clock and timing
   localparam int CLK_MHZ = 250;
   localparam int REFRESH_PERIOD_NS = 16000;
   localparam int REFRESH_CYCLES = REFRESH_PERIOD_NS * CLK_MHZ / 1000;
   localparam int REFRESH_WINDOW_NS = 2000000;
   localparam int ROW_COUNT = 128;
   localparam int WRITE_SETTLE_NS = 40;
   localparam int WRITE_SETTLE_CYCLES = (WRITE_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int REFRESH_BUSY_CYCLES = 4;
   // widths
   localparam int ROW_W = 7;
   localparam int WORD_W = 18;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 18;
   localparam int TMR_W = 12;
   localparam int CNT_W = 4;
   localparam int PIN_W = 92;
   // bit positions of the two stored parity bits
   localparam int PAR_LO_BIT = 16;
   localparam int PAR_HI_BIT = 17;
   // position of the correction error flag in the pin synchroniser word
   localparam int CEF_PIN_BIT = 79;
   // correction board modes on the mode lines
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_STATUS = 3'h3;
   localparam logic [2:0] MODE_WRITE_DATA_ONLY = 3'h4;
   // reset values
   localparam logic [15:0] ROW_STROBE_IDLE = 16'hFFFF;
   localparam logic [WORD_W-1:0] DATA_RESET = 18'h00000;
   // pins idle high except the error flag, which must not latch an error at reset
   localparam logic [PIN_W-1:0] PIN_IDLE = ~(PIN_W'(1'b1) << CEF_PIN_BIT);
   localparam logic [DATA_W-1:0] STATUS_ADDR = 16'h0000;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_REFRESH = 4'h1,
      ST_SETTLE = 4'h2,
      ST_READ = 4'h3,
      ST_CHECK = 4'h4,
      ST_CORR = 4'h5,
      ST_READY = 4'h6,
      ST_WRITE = 4'h7,
      ST_WDONE = 4'h8
   } cycle_state_type;
endpackage : dram_board_pkg

// >>> verilog/word_store.sv
// storage array of the board with registered read data
`timescale 1ns/1ps
module word_store (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [dram_board_pkg::ADDR_W-1:0] addr,
   input wire logic [dram_board_pkg::WORD_W-1:0] wdata,
   output logic [dram_board_pkg::WORD_W-1:0] rdata
);
   import dram_board_pkg::*;

   logic [WORD_W-1:0] mem [0:(1 << ADDR_W)-1];

   // array itself holds no reset, like real dram
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   // read data always comes out of a register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= DATA_RESET;
      end else begin
         rdata <= mem[addr];
      end
   end
endmodule : word_store

// >>> verilog/parity_dram_memory_board.sv
// memory board: self select, refresh, byte parity and bus handshake
// Notes on behaviour
// - own refresh timer issues a refresh cycle every 16 us.
// - refresh wins when refresh and bus request compete.
// - all 128 rows refreshed once every 2.048 ms, 128 periods of 16 us.
// - refresh expiring during a bus cycle waits until that cycle ends.
// - request arriving during refresh is stalled until refresh completes.
// - without correction board, two byte parity bits stored on each write.
// - read recomputes parity and flags an error on mismatch.
// - parity error without protect option forces zero bus data until the interrupt line or reset clears it.
// - board answers only when switch equals extended address lines 16 to 19.
// - extended lines 16 and 17 with address bits 15 and 14 pick one of sixteen row strobes, per population.
// - in status mode a read of address zero returns one board's status.
// - board with priority-in answers status, then raises priority-out after read.
// - read data valid at ready and held until request released.
// - drivers stay off while memory write is asserted.
// - correction error flag without options forces zero data, reset clears.
// - check-bit write control suppressed in write-data-only mode.
// - correction mode gives one extra load of the corrected word.
// - data ready marks read data valid and write completion.
// - non-inhibitable interrupt line clears the parity error latch.
// - force inputs store inverted parity for their byte on writes.
// - memory protect inhibits the cycle, location neither read nor written.
`timescale 1ns/1ps
module parity_dram_memory_board (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic mem_request_n,
   input wire logic mem_write_n,
   input wire logic stop_read_n,
   input wire logic ext_addr_bit16_n,
   input wire logic ext_addr_bit17_n,
   input wire logic ext_addr_bit18_n,
   input wire logic ext_addr_bit19_n,
   input wire logic [dram_board_pkg::DATA_W-1:0] addr,
   input wire logic [dram_board_pkg::DATA_W-1:0] bus_data_lines_in,
   input wire logic priority_in_n,
   input wire logic nonmask_irq_line_n,
   input wire logic force_bad_parity_low_n,
   input wire logic force_bad_parity_high_n,
   input wire logic mem_protect_inhibit_n,
   input wire logic correction_error_flag,
   input wire logic correction_mode_clock_n,
   input wire logic ecc_present_n,
   input wire logic parity_protect_option_n,
   input wire logic mem_management_board_n,
   input wire logic [2:0] ecc_mode,
   input wire logic [3:0] board_switch,
   input wire logic [3:0] population_switch,
   input wire logic [dram_board_pkg::DATA_W-1:0] ecc_status_word,
   input wire logic [dram_board_pkg::DATA_W-1:0] corrected_data,
   output logic [dram_board_pkg::WORD_W-1:0] bus_data_lines_out,
   output logic bus_data_lines_oe,
   output logic mem_data_ready,
   output logic board_select,
   output logic [15:0] row_strobe_n,
   output logic priority_out_n,
   output logic checkbit_write_ctl_n,
   output logic parity_error_n,
   output logic data_load_pulse,
   output logic [dram_board_pkg::ROW_W-1:0] refresh_row
);
   import dram_board_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0] sync1;
      logic [PIN_W-1:0] sync2;
      cycle_state_type st;
      logic [CNT_W-1:0] cnt;
      logic [TMR_W-1:0] tmr;
      logic pend;
      logic [ROW_W-1:0] row;
      logic par_err;
      logic ecc_err;
      logic inhibit;
      logic status_rd;
      logic [ADDR_W-1:0] addr_q;
      logic [WORD_W-1:0] dout;
      logic oe;
      logic rdy;
      logic sel;
      logic [15:0] ras_n;
      logic pri_out_n;
      logic cbw_n;
      logic perr_n;
      logic load;
   } board_state_type;

   board_state_type q;
   board_state_type d;

   // odd parity over one byte
   function automatic logic byte_parity(input logic [7:0] b);
      byte_parity = ~(^b);
   endfunction : byte_parity

   // strobe mask of every populated bank, four strobes per bank
   function automatic logic [15:0] bank_mask(input logic [3:0] pop);
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < 4; i++) begin
         m[i*4 +: 4] = pop[i] ? 4'hF : 4'h0;
      end
      bank_mask = m;
   endfunction : bank_mask

   // synchronised pin copies, all read from the second stage only
   logic p_req_n, p_wr_n, p_stop_read_n_n, p_pin_n, p_nmi_n, p_fl_n, p_fh_n, p_prot_n;
   logic p_cef, p_ecm_n, p_ecc_n, p_pp_n, p_mms_n;
   logic [3:0] p_ext_n, p_bsw, p_pop;
   logic [2:0] p_mode;
   logic [DATA_W-1:0] p_addr, p_data, p_stat, p_corr;
   logic [WORD_W-1:0] mem_rdata;
   logic [WORD_W-1:0] mem_wdata;
   logic mem_we;

   assign {p_req_n, p_wr_n, p_stop_read_n_n, p_ext_n, p_pin_n, p_nmi_n, p_fl_n, p_fh_n, p_prot_n,
           p_cef, p_ecm_n, p_ecc_n, p_pp_n, p_mms_n, p_mode, p_bsw, p_pop, p_addr, p_data,
           p_stat, p_corr} = q.sync2;

   // write word: data plus parity, force inputs flip a byte's parity
   assign mem_wdata = {byte_parity(p_data[15:8]) ^ ~p_fh_n,
                       byte_parity(p_data[7:0]) ^ ~p_fl_n, p_data};
   assign mem_we = (q.st == ST_WRITE) && !q.inhibit;

   word_store u_store (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .we(mem_we),
      .addr(q.addr_q),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // next-state logic for the whole board
   always_comb begin
      logic sel_now;
      logic status_mode;
      logic [1:0] bank;
      logic [3:0] ras_idx;
      sel_now = (~p_ext_n) == p_bsw;
      status_mode = (p_mode == MODE_STATUS);
      bank = ~p_ext_n[1:0];
      ras_idx = {bank, p_addr[15:14]};
      d = q;
      d.sync1 = {mem_request_n, mem_write_n, stop_read_n, ext_addr_bit19_n, ext_addr_bit18_n,
                 ext_addr_bit17_n, ext_addr_bit16_n, priority_in_n, nonmask_irq_line_n,
                 force_bad_parity_low_n, force_bad_parity_high_n, mem_protect_inhibit_n,
                 correction_error_flag, correction_mode_clock_n, ecc_present_n,
                 parity_protect_option_n, mem_management_board_n, ecc_mode, board_switch,
                 population_switch, addr, bus_data_lines_in, ecc_status_word, corrected_data};
      d.sync2 = q.sync1;
      d.load = 1'b0;
      // interrupt line clears the parity latch; a new error below still wins
      if (!p_nmi_n) begin
         d.par_err = 1'b0;
      end
      // leaving status mode re-arms the priority chain for the next round
      if (!status_mode) begin
         d.pri_out_n = 1'b1;
      end
      case (q.st)
         ST_IDLE: begin
            d.rdy = 1'b0;
            d.oe = 1'b0;
            d.ras_n = ROW_STROBE_IDLE;
            d.cbw_n = 1'b1;
            // refresh checked first so it beats a waiting request
            if (q.pend) begin
               d.st = ST_REFRESH;
               d.pend = 1'b0;
               d.cnt = '0;
               d.ras_n = ~bank_mask(p_pop);
            end else if (!p_req_n && sel_now) begin
               d.st = ST_SETTLE;
               d.cnt = '0;
               d.sel = 1'b1;
            end
         end
         ST_REFRESH: begin
            // requests simply wait in the synchroniser until idle returns
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == CNT_W'(REFRESH_BUSY_CYCLES - 1)) begin
               d.row = q.row + 1'b1;
               d.ras_n = ROW_STROBE_IDLE;
               d.st = ST_IDLE;
            end
         end
         ST_SETTLE: begin
            // wait out the write skew so a plain write never looks like a read
            d.cnt = q.cnt + 1'b1;
            if (p_req_n) begin
               d.st = ST_IDLE;
               d.sel = 1'b0;
            end else if (q.cnt == CNT_W'(WRITE_SETTLE_CYCLES - 1)) begin
               d.inhibit = !p_prot_n;
               d.addr_q = {bank, p_addr};
               d.status_rd = status_mode && p_wr_n && (p_addr == STATUS_ADDR)
                             && !p_pin_n && q.pri_out_n;
               if (!p_prot_n || !p_pop[bank]) begin
                  d.ras_n = ROW_STROBE_IDLE;
               end else begin
                  d.ras_n[ras_idx] = 1'b0;
               end
               if (d.status_rd) begin
                  d.dout = {2'b00, p_stat};
                  d.st = ST_READY;
               end else if (!p_wr_n) begin
                  d.st = ST_WRITE;
               end else begin
                  d.st = ST_READ;
               end
            end
         end
         ST_READ: begin
            d.st = ST_CHECK;
         end
         ST_CHECK: begin
            // parity only checked when no correction board owns the check bits
            if (p_ecc_n && ((byte_parity(mem_rdata[7:0]) != mem_rdata[PAR_LO_BIT]) ||
                (byte_parity(mem_rdata[15:8]) != mem_rdata[PAR_HI_BIT]))) begin
               d.par_err = 1'b1;
            end
            d.dout = q.inhibit ? DATA_RESET : mem_rdata;
            d.st = (!p_ecm_n && !p_ecc_n) ? ST_CORR : ST_READY;
         end
         ST_CORR: begin
            // one extra load of the corrected word costs one cycle of latency
            d.dout[DATA_W-1:0] = p_corr;
            d.load = 1'b1;
            d.st = ST_READY;
         end
         ST_READY: begin
            d.rdy = 1'b1;
            d.oe = p_wr_n && p_stop_read_n_n;
            if (p_req_n) begin
               d.st = ST_IDLE;
               d.rdy = 1'b0;
               d.oe = 1'b0;
               d.sel = 1'b0;
               d.ras_n = ROW_STROBE_IDLE;
               if (q.status_rd) begin
                  d.pri_out_n = 1'b0;
               end
               d.status_rd = 1'b0;
            end else if (!p_wr_n) begin
               d.st = ST_WRITE; // write half of read-modify-write
               d.rdy = 1'b0;
               d.oe = 1'b0;
               d.status_rd = 1'b0;
            end
         end
         ST_WRITE: begin
            d.oe = 1'b0;
            d.cbw_n = (p_mode == MODE_WRITE_DATA_ONLY) || q.inhibit;
            d.st = ST_WDONE;
         end
         ST_WDONE: begin
            d.rdy = 1'b1;
            d.oe = 1'b0;
            d.cbw_n = 1'b1;
            if (p_req_n) begin
               d.st = ST_IDLE;
               d.rdy = 1'b0;
               d.sel = 1'b0;
               d.ras_n = ROW_STROBE_IDLE;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      // refresh timer runs free; expiry set wins over the idle clear above
      if (q.tmr == TMR_W'(REFRESH_CYCLES - 1)) begin
         d.tmr = '0;
         d.pend = 1'b1;
      end else begin
         d.tmr = q.tmr + 1'b1;
      end
      // correction error latch only clears with reset
      if (p_cef && p_pp_n && p_mms_n) begin
         d.ecc_err = 1'b1;
      end
      // force zeros on the bus whenever an error latch holds without options
      if ((d.par_err && p_pp_n) || d.ecc_err) begin
         d.dout = DATA_RESET;
      end
      d.perr_n = ~(d.par_err | d.ecc_err);
   end

   // single state register for the whole board
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{sync1: PIN_IDLE, sync2: PIN_IDLE, st: ST_IDLE, cnt: '0, tmr: '0,
                pend: 1'b0, row: '0, par_err: 1'b0, ecc_err: 1'b0, inhibit: 1'b0,
                status_rd: 1'b0, addr_q: '0, dout: DATA_RESET, oe: 1'b0, rdy: 1'b0,
                sel: 1'b0, ras_n: ROW_STROBE_IDLE, pri_out_n: 1'b1, cbw_n: 1'b1,
                perr_n: 1'b1, load: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign bus_data_lines_out = q.dout;
   assign bus_data_lines_oe = q.oe;
   assign mem_data_ready = q.rdy;
   assign board_select = q.sel;
   assign row_strobe_n = q.ras_n;
   assign priority_out_n = q.pri_out_n;
   assign checkbit_write_ctl_n = q.cbw_n;
   assign parity_error_n = q.perr_n;
   assign data_load_pulse = q.load;
   assign refresh_row = q.row;

   property p_refresh_period;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tmr == TMR_W'(REFRESH_CYCLES - 1)) |=> q.pend || q.st == ST_REFRESH;
   endproperty
   a_refresh_period: assert property (p_refresh_period) else $error("refresh not pending");

   property p_refresh_first;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.st == ST_IDLE && q.pend && !p_req_n) |=> (q.st == ST_REFRESH);
   endproperty
   a_refresh_first: assert property (p_refresh_first) else $error("refresh lost priority");

   property p_row_step;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.st == ST_REFRESH && d.st == ST_IDLE) |=> (q.row == $past(q.row) + 7'h01);
   endproperty
   a_row_step: assert property (p_row_step) else $error("refresh row did not step");

   property p_refresh_stall;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(q.st == ST_REFRESH) |-> !q.rdy [*4];
   endproperty
   a_refresh_stall: assert property (p_refresh_stall) else $error("ready during refresh");

   property p_no_drive_on_write;
      @(posedge sys_clk) disable iff (!rst_n)
      !p_wr_n |=> !bus_data_lines_oe;
   endproperty
   a_no_drive_on_write: assert property (p_no_drive_on_write) else $error("driving on write");

   property p_ready_selected;
      @(posedge sys_clk) disable iff (!rst_n)
      mem_data_ready |-> board_select;
   endproperty
   a_ready_selected: assert property (p_ready_selected) else $error("unselected ready");

   property p_zero_data;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.ecc_err || (q.par_err && p_pp_n)) |=> (bus_data_lines_out == DATA_RESET);
   endproperty
   a_zero_data: assert property (p_zero_data) else $error("error data not zero");

   property p_checkbit_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.st == ST_WRITE && p_mode == MODE_WRITE_DATA_ONLY) |=> checkbit_write_ctl_n;
   endproperty
   a_checkbit_hold: assert property (p_checkbit_hold) else $error("check bits written");

   property p_priority_after_status;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(priority_out_n) |-> $past(q.status_rd) && $past(p_req_n);
   endproperty
   a_priority_after_status: assert property (p_priority_after_status)
      else $error("priority out early");

   property p_data_held;
      @(posedge sys_clk) disable iff (!rst_n)
      (mem_data_ready && $past(mem_data_ready) && q.st == ST_READY)
         |-> $stable(bus_data_lines_out) || q.ecc_err || q.par_err;
   endproperty
   a_data_held: assert property (p_data_held) else $error("read data moved");
endmodule : parity_dram_memory_board

// >>> test/bus_requester.sv
// processor-side requester model for the memory handshake
`timescale 1ns/1ps
module bus_requester (
   input wire logic sys_clk,
   input wire logic mem_data_ready,
   input wire logic bus_data_lines_oe,
   input wire logic [17:0] bus_data_lines_out,
   output logic mem_request_n,
   output logic mem_write_n,
   output logic stop_read_n,
   output logic [15:0] addr,
   output logic [15:0] wdata
);
   localparam int OFF_CYCLES = 25; // 100 ns off time
   localparam int READ_LIMIT = 400; // 1.6 us ceiling per request
   initial begin
      mem_request_n = 1'b1;
      mem_write_n = 1'b1;
      stop_read_n = 1'b1;
      addr = 16'h0000;
      wdata = 16'h0000;
   end
   // bounded wait for ready at a level
   task automatic wait_level(input logic lvl, input int lim, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < lim && !ok; n++) begin
         @(posedge sys_clk);
         ok = (mem_data_ready === lvl);
      end
   endtask : wait_level
   // drop everything; released data lines flip so stale values never match
   task automatic release_bus();
      mem_request_n <= 1'b1;
      mem_write_n <= 1'b1;
      stop_read_n <= 1'b1;
      wdata <= ~wdata;
      repeat (OFF_CYCLES) @(posedge sys_clk);
   endtask : release_bus
   // plain read or write, answer taken at the ready edge
   task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
         output logic [17:0] q, output logic oe, output logic ok);
      addr <= a;
      wdata <= d;
      mem_request_n <= 1'b0;
      mem_write_n <= !wr; // same edge as request
      wait_level(1'b1, READ_LIMIT, ok);
      q = bus_data_lines_out;
      oe = bus_data_lines_oe;
      release_bus();
   endtask : access
   // read, stop read, write 100 ns later; whole cycle far inside 2 us
   task automatic rmw(input logic [15:0] a, input logic [15:0] d,
         output logic [17:0] q, output logic ok);
      logic ok1;
      logic ok2;
      addr <= a;
      mem_request_n <= 1'b0;
      wait_level(1'b1, READ_LIMIT, ok);
      q = bus_data_lines_out;
      stop_read_n <= 1'b0;
      wdata <= d;
      repeat (OFF_CYCLES) @(posedge sys_clk);
      mem_write_n <= 1'b0;
      stop_read_n <= 1'b1;
      wait_level(1'b0, 40, ok1);
      wait_level(1'b1, 40, ok2);
      ok = ok && ok1 && ok2;
      release_bus();
   endtask : rmw
endmodule : bus_requester

// >>> test/tb.sv
// testbench of the memory board driven through the requester model
`timescale 1ns/1ps
module tb;
   import dram_board_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic mem_request_n, mem_write_n, stop_read_n, ok, oe, rdy, sel, prio_n, ckw_n, perr_n, pulse;
   logic [3:0] ext_n = 4'hA; // board 5
   logic [15:0] addr, wdata, strobe_n, strobe_exp;
   logic priority_in_n = 1'b1, irq_n = 1'b1, force_lo_n = 1'b1, force_hi_n = 1'b1;
   logic protect_n = 1'b1, ecc_flag = 1'b0, corr_n = 1'b1, ecc_n = 1'b1;
   logic pp_n = 1'b1, mms_n = 1'b1, oe_cap;
   logic [3:0] pop_sw = 4'hF;
   logic [2:0] ecc_mode = MODE_OFF;
   logic [15:0] status_word = 16'h0000, corr_data = 16'h0000;
   logic [17:0] dout, q;
   logic [6:0] row;
   int fail_count = 0, total_checks = 0, ckw_seen = 0, pulses = 0, sel_seen = 0, hits = 0;
   always #2 sys_clk = ~sys_clk;
   parity_dram_memory_board i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .mem_request_n(mem_request_n), .mem_write_n(mem_write_n), .stop_read_n(stop_read_n),
      .ext_addr_bit16_n(ext_n[0]), .ext_addr_bit17_n(ext_n[1]), .ext_addr_bit18_n(ext_n[2]),
      .ext_addr_bit19_n(ext_n[3]), .addr(addr), .bus_data_lines_in(wdata),
      .priority_in_n(priority_in_n), .nonmask_irq_line_n(irq_n),
      .force_bad_parity_low_n(force_lo_n), .force_bad_parity_high_n(force_hi_n),
      .mem_protect_inhibit_n(protect_n), .correction_error_flag(ecc_flag),
      .correction_mode_clock_n(corr_n), .ecc_present_n(ecc_n),
      .parity_protect_option_n(pp_n), .mem_management_board_n(mms_n), .ecc_mode(ecc_mode),
      .board_switch(4'h5), .population_switch(pop_sw), .ecc_status_word(status_word),
      .corrected_data(corr_data), .bus_data_lines_out(dout), .bus_data_lines_oe(oe),
      .mem_data_ready(rdy), .board_select(sel), .row_strobe_n(strobe_n),
      .priority_out_n(prio_n), .checkbit_write_ctl_n(ckw_n), .parity_error_n(perr_n),
      .data_load_pulse(pulse), .refresh_row(row));
   bus_requester i_host (.sys_clk(sys_clk), .mem_data_ready(rdy), .bus_data_lines_oe(oe),
      .bus_data_lines_out(dout), .mem_request_n(mem_request_n), .mem_write_n(mem_write_n),
      .stop_read_n(stop_read_n), .addr(addr), .wdata(wdata));
   // event counters for strobes and pulses that are too short to poll
   always @(posedge sys_clk) begin
      if (ckw_n === 1'b0) ckw_seen++;
      if (pulse === 1'b1) pulses++;
      if (sel === 1'b1) sel_seen++;
      if (strobe_n === strobe_exp) hits++;
   end
   task automatic compare(input logic [17:0] seen, input logic [17:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : compare
   // odd parity per byte above the data
   function automatic logic [17:0] word_of(input logic [15:0] d);
      return {~^d[15:8], ~^d[7:0], d};
   endfunction : word_of
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      i_host.access(1'b1, a, d, q, oe_cap, ok);
   endtask : wr
   task automatic rd(input logic [15:0] a);
      i_host.access(1'b0, a, 16'h0000, q, oe_cap, ok);
   endtask : rd
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
   endtask : do_reset
   task automatic t_refresh();
      logic [6:0] r0;
      logic [6:0] r1;
      int n;
      for (int k = 0; k < 2; k++) begin
         r0 = row;
         n = 0;
         while (row === r0 && n < 4100) begin
            @(posedge sys_clk);
            n++;
         end
      end
      r1 = r0 + 7'h01;
      compare(n == REFRESH_CYCLES, 1'b1);
      compare(row, r1);
   endtask : t_refresh
   task automatic t_basic();
      strobe_exp = ~(16'h0001 << 4); // bank 1, top address bits 00
      sel_seen = 0;
      hits = 0;
      wr(16'h0123, 16'hA53C);
      compare(ok, 1'b1);
      compare(oe_cap, 1'b0);
      rd(16'h0123);
      compare(q, word_of(16'hA53C));
      compare(oe_cap, 1'b1);
      compare(sel_seen > 0, 1'b1);
      compare(hits > 0, 1'b1);
      ext_n <= ~4'h6;
      sel_seen = 0;
      rd(16'h0123);
      compare(ok, 1'b0);
      compare(sel_seen == 0, 1'b1);
      ext_n <= ~4'h5;
      repeat (4) @(posedge sys_clk);
   endtask : t_basic
   task automatic t_parity();
      for (int b = 0; b < 2; b++) begin
         force_lo_n <= (b != 0);
         force_hi_n <= (b != 1);
         wr(16'h0200, 16'h5AF0);
         force_lo_n <= 1'b1;
         force_hi_n <= 1'b1;
         rd(16'h0200);
         compare(q, 18'h00000);
         compare(perr_n, 1'b0);
         irq_n <= 1'b0;
         repeat (4) @(posedge sys_clk);
         irq_n <= 1'b1;
         repeat (4) @(posedge sys_clk);
         compare(perr_n, 1'b1);
      end
   endtask : t_parity
   // protect option keeps bad data visible; an empty bank gets no strobe
   task automatic t_options();
      pp_n <= 1'b0;
      force_lo_n <= 1'b0;
      wr(16'h0700, 16'h0F00);
      force_lo_n <= 1'b1;
      rd(16'h0700);
      compare(q, word_of(16'h0F00) ^ 18'h10000);
      compare(perr_n, 1'b0);
      irq_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      irq_n <= 1'b1;
      pp_n <= 1'b1;
      pop_sw <= 4'hD; // bank 1 left empty
      hits = 0;
      rd(16'h0123);
      compare(hits == 0, 1'b1);
      pop_sw <= 4'hF;
   endtask : t_options
   task automatic t_protect_rmw();
      wr(16'h0300, 16'h1111);
      protect_n <= 1'b0;
      wr(16'h0300, 16'h2222);
      rd(16'h0300);
      compare(q, 18'h00000);
      protect_n <= 1'b1;
      rd(16'h0300);
      compare(q, word_of(16'h1111));
      wr(16'h0400, 16'hC3C3);
      i_host.rmw(16'h0400, 16'h0F0F, q, ok);
      compare(q, word_of(16'hC3C3));
      compare(ok, 1'b1);
      rd(16'h0400);
      compare(q, word_of(16'h0F0F));
   endtask : t_protect_rmw
   task automatic t_ecc();
      ecc_n <= 1'b0;
      ckw_seen = 0;
      wr(16'h0500, 16'h7777);
      compare(ckw_seen == 1, 1'b1);
      ecc_mode <= MODE_WRITE_DATA_ONLY;
      ckw_seen = 0;
      wr(16'h0500, 16'h7777);
      compare(ckw_seen == 0, 1'b1);
      ecc_mode <= MODE_OFF;
      corr_data <= 16'h1234;
      corr_n <= 1'b0;
      pulses = 0;
      rd(16'h0500);
      compare(pulses == 1, 1'b1);
      compare(q[15:0], 16'h1234);
      corr_n <= 1'b1;
      ecc_mode <= MODE_STATUS;
      priority_in_n <= 1'b0;
      status_word <= 16'h8421;
      repeat (4) @(posedge sys_clk);
      compare(prio_n, 1'b1);
      rd(STATUS_ADDR);
      compare(q, {2'b00, 16'h8421});
      compare(prio_n, 1'b0);
      ecc_mode <= MODE_OFF;
      priority_in_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      compare(prio_n, 1'b1);
   endtask : t_ecc
   task automatic t_flag();
      mms_n <= 1'b0;
      ecc_flag <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ecc_flag <= 1'b0;
      rd(16'h0500);
      compare(q, word_of(16'h7777));
      mms_n <= 1'b1;
      ecc_flag <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ecc_flag <= 1'b0;
      irq_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      irq_n <= 1'b1;
      rd(16'h0500);
      compare(q, 18'h00000);
      do_reset();
      ecc_n <= 1'b1;
      wr(16'h0600, 16'h6006);
      rd(16'h0600);
      compare(q, word_of(16'h6006));
   endtask : t_flag
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   // main sequence
   initial begin
      do_reset();
      t_refresh();
      t_basic();
      t_parity();
      t_options();
      t_protect_rmw();
      t_ecc();
      t_flag();
      give_verdict();
   end
   // a hung handshake ends the run well past the expected length
   initial begin
      repeat (60000) @(posedge sys_clk);
      fail_count++;
      give_verdict();
   end
endmodule : tb
